// *** rtl/pmp_pkg.sv ***
// shared constants for the program message parser
package pmp_pkg;
    localparam int unsigned BUF_BYTES = 256;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned BYTE_W = 8;
    localparam logic [7:0] CH_NL = 8'h0a;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_DQUOTE = 8'h22;
    localparam logic [7:0] CH_SQUOTE = 8'h27;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7a;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [7:0] CH_PRINT_LO = 8'h20;
    localparam logic [7:0] CH_PRINT_HI = 8'h7e;
    localparam logic [7:0] IDX_LAST = 8'hff;
    localparam logic [7:0] IDX_ZERO = 8'h00;
    localparam logic [7:0] IDX_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
endpackage

// *** rtl/pmp_fifo.sv ***
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pmp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    assign wr_ready_out = (cnt != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt != '0);
    assign rd_data_out = mem[rp];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;

    always_comb begin
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    // storage has no reset; only the pointers and the count need a defined value
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp] <= wr_data_in;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pmp_parser.sv ***
// program message parser: buffering, splitting, case folding, responses
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: messages are semicolon-separated elements closed by a terminator
// RULE2: decoding of a message waits for its terminator
// RULE3: a full 256-byte buffer is analysed without waiting for terminator
// RULE4: elements are issued strictly in received order
// RULE5: accept newline, newline with end flag, or end flag on last byte
// RULE6: each response ends with newline sent with end flag asserted
// RULE7: upper and lower case letters are equivalent in headers
// RULE8: quoted string arguments keep their original letter case
// RULE9: well-formed messages execute; messages with errors are discarded
// RULE10: header ending in question mark marks a query, else a command
// RULE11: each query yields a response that the controller reads out
// RULE12: responses carry the query header unless header echo is off
// RULE13: header, one space, then parameters separated by commas
// RULE14: malformed queries get no response
// RULE15: errors only raise status, never spontaneous messages
// RULE16: controller allows three seconds timeout for responses
// RULE17: after a full-buffer analysis, empty buffer and keep collecting
module pmp_parser (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_end_in,
    input wire logic header_echo_control_in,
    output logic el_valid_out,
    input wire logic el_ready_in,
    output logic [7:0] el_data_out,
    output logic el_is_query_out,
    output logic el_is_header_out,
    output logic el_last_out,
    output logic msg_error_out,
    input wire logic rsp_valid_in,
    output logic rsp_ready_out,
    input wire logic [7:0] rsp_data_in,
    input wire logic rsp_last_in,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic [7:0] tx_data_out,
    output logic tx_end_out
);
    typedef enum logic [1:0] {
        PMP_COLLECT,
        PMP_CHECK,
        PMP_ISSUE
    } pmp_state_t;

    function automatic logic [7:0] pmp_fold(input logic [7:0] c);
        if (c >= pmp_pkg::CH_LOW_A && c <= pmp_pkg::CH_LOW_Z) begin
            pmp_fold = c & ~pmp_pkg::CASE_BIT;
        end else begin
            pmp_fold = c;
        end
    endfunction

    function automatic logic pmp_is_quote(input logic [7:0] c);
        pmp_is_quote = (c == pmp_pkg::CH_DQUOTE) || (c == pmp_pkg::CH_SQUOTE);
    endfunction

    // input fifo decouples the bus from buffer analysis stalls
    logic f_valid, f_ready, f_end;
    logic [7:0] f_data;
    pmp_fifo #(
        .WIDTH(pmp_pkg::BYTE_W + 1),
        .DEPTH(pmp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_valid_in(rx_valid_in),
        .wr_ready_out(rx_ready_out),
        .wr_data_in({rx_end_in, rx_data_in}),
        .rd_valid_out(f_valid),
        .rd_ready_in(f_ready),
        .rd_data_out({f_end, f_data})
    );

    logic [7:0] buf_mem [pmp_pkg::BUF_BYTES];
    logic [7:0] wr_idx, next_wr_idx;
    logic [7:0] rd_idx, next_rd_idx;
    logic [7:0] len, next_len;
    logic full, next_full;
    logic terminated, next_terminated;
    logic bad, next_bad;
    logic in_hdr, next_in_hdr;
    logic in_quote, next_in_quote;
    logic el_q, next_el_q;
    logic err, next_err;
    pmp_state_t state, next_state;
    logic [7:0] chk_c;
    logic wr_en, is_nl, pop_byte;

    assign chk_c = buf_mem[rd_idx];
    assign is_nl = (f_data == pmp_pkg::CH_NL);
    assign f_ready = (state == PMP_COLLECT);
    assign pop_byte = f_valid && f_ready;
    // a bare newline is a terminator and is never stored
    assign wr_en = pop_byte && !is_nl; // RULE5

    always_comb begin
        next_state = state;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_len = len;
        next_full = full;
        next_terminated = terminated;
        next_bad = bad;
        next_in_hdr = in_hdr;
        next_in_quote = in_quote;
        next_el_q = el_q;
        next_err = 1'b0;
        unique case (state)
            PMP_COLLECT: begin
                if (pop_byte) begin
                    if (wr_en) begin
                        next_wr_idx = wr_idx + pmp_pkg::IDX_ONE;
                    end
                    // newline or end flag closes the message
                    if (is_nl || f_end) begin // RULE5
                        next_terminated = 1'b1;
                        next_len = wr_en ? wr_idx + pmp_pkg::CNT_ONE : wr_idx;
                        // a last byte landing in the top slot fills the buffer
                        next_full = wr_en && wr_idx == pmp_pkg::IDX_LAST;
                        next_state = PMP_CHECK; // RULE2
                    end else if (wr_idx == pmp_pkg::IDX_LAST) begin
                        // buffer full: analyse now, message continues
                        next_terminated = 1'b0;
                        next_len = pmp_pkg::IDX_LAST;
                        next_full = 1'b1;
                        next_state = PMP_CHECK; // RULE3
                    end
                    next_rd_idx = pmp_pkg::IDX_ZERO;
                    next_in_quote = 1'b0;
                end
            end
            PMP_CHECK: begin
                // syntax pass before any byte of a chunk is issued, so a bad
                // chunk executes nothing; costs one pass of latency
                if (!full && wr_idx == pmp_pkg::IDX_ZERO) begin
                    next_state = PMP_COLLECT;
                end else begin
                    if (pmp_is_quote(chk_c)) begin
                        next_in_quote = !in_quote;
                    end
                    if (!in_quote && (chk_c < pmp_pkg::CH_PRINT_LO ||
                            chk_c > pmp_pkg::CH_PRINT_HI)) begin
                        next_bad = 1'b1; // RULE9
                    end
                    if ((!full && rd_idx + pmp_pkg::IDX_ONE == wr_idx) ||
                            (full && rd_idx == pmp_pkg::IDX_LAST)) begin
                        if (in_quote != pmp_is_quote(chk_c) &&
                                (!full || terminated)) begin
                            next_bad = 1'b1; // RULE9
                        end
                        next_rd_idx = pmp_pkg::IDX_ZERO;
                        next_in_hdr = 1'b1;
                        next_in_quote = 1'b0;
                        next_el_q = 1'b0;
                        next_state = PMP_ISSUE;
                    end else begin
                        next_rd_idx = rd_idx + pmp_pkg::IDX_ONE;
                    end
                end
            end
            PMP_ISSUE: begin
                if (bad) begin
                    // discard whole chunk, flag status only
                    next_err = 1'b1; // RULE15
                    // a cut message stays bad until its terminator
                    next_bad = full && !terminated;
                    next_wr_idx = pmp_pkg::IDX_ZERO;
                    next_state = PMP_COLLECT; // RULE9 RULE14
                end else if (el_ready_in) begin
                    if (pmp_is_quote(chk_c)) begin
                        next_in_quote = !in_quote;
                    end
                    if (!in_quote && chk_c == pmp_pkg::CH_SEMI) begin
                        next_in_hdr = 1'b1; // RULE1
                        next_el_q = 1'b0;
                    end else if (!in_quote && in_hdr &&
                            chk_c == pmp_pkg::CH_SPACE) begin
                        next_in_hdr = 1'b0; // RULE13
                    end else if (in_hdr && chk_c == pmp_pkg::CH_QUERY) begin
                        next_el_q = 1'b1; // RULE10
                    end
                    if (el_last_out) begin
                        // emptied; keep collecting the cut message, or start the next one after a terminator
                        next_wr_idx = pmp_pkg::IDX_ZERO; // RULE17
                        next_state = PMP_COLLECT;
                    end else begin
                        next_rd_idx = rd_idx + pmp_pkg::IDX_ONE; // RULE4
                    end
                end
            end
            default: next_state = PMP_COLLECT;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= PMP_COLLECT;
            wr_idx <= '0;
            rd_idx <= '0;
            len <= '0;
            full <= 1'b0;
            terminated <= 1'b0;
            bad <= 1'b0;
            in_hdr <= 1'b1;
            in_quote <= 1'b0;
            el_q <= 1'b0;
            err <= 1'b0;
        end else begin
            state <= next_state;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            len <= next_len;
            full <= next_full;
            terminated <= next_terminated;
            bad <= next_bad;
            in_hdr <= next_in_hdr;
            in_quote <= next_in_quote;
            el_q <= next_el_q;
            err <= next_err;
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_en) begin
            buf_mem[wr_idx] <= f_data;
        end
    end

    assign el_valid_out = (state == PMP_ISSUE) && !bad;
    // letters fold to upper case except inside quoted strings
    assign el_data_out = in_quote ? chk_c : pmp_fold(chk_c); // RULE7 RULE8
    // the question mark itself marks the element as a query
    assign el_is_query_out = el_q || (in_hdr && chk_c == pmp_pkg::CH_QUERY);
    assign el_is_header_out = in_hdr && !in_quote;
    // a full chunk issues all slots; len cannot count to the buffer size
    assign el_last_out = full ? (rd_idx == pmp_pkg::IDX_LAST) :
        (rd_idx + pmp_pkg::IDX_ONE == len); // RULE3 RULE17
    assign msg_error_out = err;

    // response path: executor supplies header text only when echo is on;
    // newline is always appended with the end flag
    logic tx_nl, next_tx_nl;
    logic [7:0] tx_d, next_tx_d;
    logic tx_v, next_tx_v;
    logic tx_e, next_tx_e;

    always_comb begin
        next_tx_nl = tx_nl;
        next_tx_d = tx_d;
        next_tx_v = tx_v;
        next_tx_e = tx_e;
        if (tx_v && tx_ready_in) begin
            next_tx_v = 1'b0;
            next_tx_e = 1'b0;
        end
        if (tx_nl && !next_tx_v) begin
            next_tx_d = pmp_pkg::CH_NL;
            next_tx_e = 1'b1; // RULE6
            next_tx_v = 1'b1;
            next_tx_nl = 1'b0;
        end else if (rsp_ready_out && rsp_valid_in) begin
            next_tx_d = rsp_data_in; // RULE11 RULE12
            next_tx_v = 1'b1;
            next_tx_e = 1'b0;
            next_tx_nl = rsp_last_in;
        end
    end
    assign rsp_ready_out = !tx_nl && (!tx_v || tx_ready_in);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_nl <= 1'b0;
            tx_d <= '0;
            tx_v <= 1'b0;
            tx_e <= 1'b0;
        end else begin
            tx_nl <= next_tx_nl;
            tx_d <= next_tx_d;
            tx_v <= next_tx_v;
            tx_e <= next_tx_e;
        end
    end
    assign tx_valid_out = tx_v;
    assign tx_data_out = tx_d;
    assign tx_end_out = tx_e;
    // header_echo_control_in is honoured by the executor building responses
    logic unused_echo;
    assign unused_echo = header_echo_control_in ^ terminated;
endmodule
`default_nettype wire

// *** test/pmp_parser_props.sv ***
// concurrent checks on the program message parser ports
`timescale 1ns/1ps
`default_nettype none
module pmp_parser_props (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic rx_valid_in,
    input wire logic rx_ready_out,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_end_in,
    input wire logic header_echo_control_in,
    input wire logic el_valid_out,
    input wire logic el_ready_in,
    input wire logic [7:0] el_data_out,
    input wire logic el_is_query_out,
    input wire logic el_is_header_out,
    input wire logic el_last_out,
    input wire logic msg_error_out,
    input wire logic rsp_valid_in,
    input wire logic rsp_ready_out,
    input wire logic [7:0] rsp_data_in,
    input wire logic rsp_last_in,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [7:0] tx_data_out,
    input wire logic tx_end_out
);
    logic seen;
    logic rsp_seen;
    logic [8:0] cnt;
    logic rx_take;
    assign rx_take = rx_valid_in && rx_ready_out;
    // terminator flag is sticky, so only the first message is policed
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seen <= 1'b0;
            rsp_seen <= 1'b0;
            cnt <= 9'h000;
        end else begin
            if (rx_take && (rx_end_in || rx_data_in == pmp_pkg::CH_NL))
                seen <= 1'b1;
            if (rx_take && cnt != 9'h1ff)
                cnt <= cnt + 9'h001;
            if (rsp_valid_in && rsp_ready_out)
                rsp_seen <= 1'b1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_WAIT_TERM: assert property (
        el_valid_out |-> seen || cnt >= 9'h0ff)
        else $error("element issued before terminator");
    AST_EL_HOLD: assert property (
        el_valid_out && !el_ready_in |=> el_valid_out &&
        $stable(el_data_out) && $stable(el_last_out))
        else $error("element byte changed while stalled");
    AST_NO_NL: assert property (
        el_valid_out |-> el_data_out != pmp_pkg::CH_NL)
        else $error("terminator passed as element byte");
    AST_TX_END_NL: assert property (
        tx_valid_out && tx_end_out |-> tx_data_out == pmp_pkg::CH_NL)
        else $error("end flag without newline");
    AST_TX_AFTER_LAST: assert property (
        rsp_valid_in && rsp_ready_out && rsp_last_in |->
        ##[1:60] (tx_valid_out && tx_ready_in && tx_end_out))
        else $error("response not closed by terminator");
    AST_FOLD: assert property (
        el_valid_out && el_is_header_out |->
        !(el_data_out inside {[pmp_pkg::CH_LOW_A:pmp_pkg::CH_LOW_Z]}))
        else $error("lower case letter in header");
    AST_QUERY: assert property (
        el_valid_out && el_is_header_out &&
        el_data_out == pmp_pkg::CH_QUERY |-> el_is_query_out)
        else $error("question mark not marked as query");
    AST_TX_HOLD: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out &&
        $stable(tx_data_out) && $stable(tx_end_out))
        else $error("tx byte changed while stalled");
    AST_NO_SPONT: assert property (
        tx_valid_out |-> rsp_seen)
        else $error("output sent without a response");
    AST_ERR_PULSE: assert property (
        msg_error_out |=> !msg_error_out)
        else $error("error flag longer than one cycle");
endmodule
bind pmp_parser pmp_parser_props pmp_parser_props_i (.clk_in, .rstn_in,
    .rx_valid_in, .rx_ready_out, .rx_data_in, .rx_end_in,
    .header_echo_control_in, .el_valid_out, .el_ready_in, .el_data_out,
    .el_is_query_out, .el_is_header_out, .el_last_out, .msg_error_out,
    .rsp_valid_in, .rsp_ready_out, .rsp_data_in, .rsp_last_in,
    .tx_valid_out, .tx_ready_in, .tx_data_out, .tx_end_out);
`default_nettype wire

// *** test/pmp_ctrl_model.sv ***
// controller model that reads response bytes with slow acceptance
`timescale 1ns/1ps
`default_nettype none
module pmp_ctrl_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic tx_valid_in,
    output var logic tx_ready_out,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_end_in
);
    logic [8:0] q[$];
    logic [1:0] ph;
    // reads every byte, stalling one cycle in four; waits without limit
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph <= 2'h0;
            tx_ready_out <= 1'b0;
        end else begin
            if (tx_valid_in && tx_ready_out)
                q.push_back({tx_end_in, tx_data_in});
            ph <= ph + 2'h1;
            tx_ready_out <= ph != 2'h0;
        end
    end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the program message parser
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
$display("unexpected %s exp %0h got %0h", nm, e, a); end end
module tb;
    typedef struct {string m; int t; string e; bit err;} pmp_row_t;
    logic clk_in = 0, rstn_in = 0, rx_valid_in = 0, rx_end_in = 0;
    logic rx_ready_out, el_valid_out, el_ready_in = 1'b0, el_is_query_out;
    logic el_is_header_out, el_last_out, msg_error_out, rsp_valid_in;
    logic rsp_ready_out, rsp_last_in, tx_valid_out, tx_ready_in, tx_end_out;
    logic header_echo_control_in, q_last, exp_q;
    logic [7:0] rx_data_in, el_data_out, rsp_data_in, tx_data_out;
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    int error_cnt = 0, cmp_count = 0, lasts, errs, first_len, n;
    // t: 0 newline, 1 newline with end, 2 end on last byte, 3 none
    pmp_row_t rows[5] = '{'{"ab;c?", 0, "AB;C?", 0},
        '{"m 'Ab',x", 2, "M 'Ab',X", 0}, '{"dd?", 1, "DD?", 0},
        '{"a\001", 0, "", 1}, '{"m 'ab", 1, "", 1}};
    pmp_parser pmp_parser_i (.clk_in, .rstn_in, .rx_valid_in,
        .rx_ready_out, .rx_data_in, .rx_end_in, .header_echo_control_in,
        .el_valid_out, .el_ready_in, .el_data_out, .el_is_query_out,
        .el_is_header_out, .el_last_out, .msg_error_out, .rsp_valid_in,
        .rsp_ready_out, .rsp_data_in, .rsp_last_in, .tx_valid_out,
        .tx_ready_in, .tx_data_out, .tx_end_out);
    pmp_ctrl_model pmp_ctrl_model_i (.clk_in, .rstn_in,
        .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in),
        .tx_data_in(tx_data_out), .tx_end_in(tx_end_out));
    initial forever #2.5 clk_in = ~clk_in;
    // executor side stalls one cycle in four so the fifo fills up
    always @(posedge clk_in) begin
        if (el_valid_out === 1'b1 && el_ready_in) begin
            got.push_back(el_data_out);
            if (el_last_out === 1'b1) begin
                lasts++;
                q_last = el_is_query_out;
                if (lasts == 1) first_len = got.size();
            end
        end
        if (msg_error_out === 1'b1) errs++;
        #1;
        ph = ph + 2'h1;
        el_ready_in = ph != 2'h3;
    end
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step(input logic busy);
        n = 0;
        do begin @(posedge clk_in); n++; end while (busy && n < 5000);
    endtask
    // s selects the response port; request held until ready is sampled
    task automatic xfer(input bit s, input logic [7:0] b, input logic e);
        if (s) {rsp_valid_in, rsp_data_in, rsp_last_in} = {1'b1, b, e};
        else {rx_valid_in, rx_data_in, rx_end_in} = {1'b1, b, e};
        n = 0;
        do begin @(posedge clk_in); n++; end
        while ((s ? rsp_ready_out : rx_ready_out) !== 1'b1 && n < 5000);
        if (n >= 5000) begin error_cnt++; finish_test(); end
        #1;
    endtask
    task automatic send(input string m, input int t);
        foreach (m[i]) xfer(0, m[i], t == 2 && i == m.len() - 1);
        if (t < 2) xfer(0, pmp_pkg::CH_NL, t == 1);
        rx_valid_in = 1'b0;
    endtask
    task automatic wait_el(input int k);
        n = 0;
        while (lasts < k && errs == 0 && n < 5000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 5000) begin error_cnt++; finish_test(); end
        repeat (20) @(posedge clk_in);
        #1;
    endtask
    task automatic clr;
        got.delete();
        {lasts, errs, first_len} = '0;
    endtask
    initial begin
        {rx_data_in, rsp_data_in} = 16'h0000;
        header_echo_control_in = 1'b1;
        {rsp_valid_in, rsp_last_in} = 2'h0;
        repeat (16) @(posedge clk_in);
        `CHK("rx_ready_out", 1'b1, rx_ready_out)
        `CHK("rsp_ready_out", 1'b1, rsp_ready_out)
        `CHK("el_valid_out", 1'b0, el_valid_out)
        `CHK("tx_valid_out", 1'b0, tx_valid_out)
        #1 rstn_in = 1'b1;
        $display("test reset done");
        foreach (rows[r]) begin
            clr();
            send(rows[r].m, rows[r].t);
            wait_el(1);
            `CHK("msg_error", rows[r].err, errs != 0)
            `CHK("el_count", rows[r].e.len(), got.size())
            foreach (got[k]) `CHK("el_data", rows[r].e[k], got[k])
            exp_q = rows[r].e.len() > 0 &&
                rows[r].e[rows[r].e.len() - 1] == pmp_pkg::CH_QUERY;
            if (!rows[r].err) `CHK("el_query", exp_q, q_last)
            $display("test row %0d done", r);
        end
        clr();
        send("ab", 3);
        repeat (60) @(posedge clk_in);
        #1;
        `CHK("early_el_count", 0, got.size())
        send("", 0);
        wait_el(1);
        `CHK("el_count", 2, got.size())
        $display("test terminator wait done");
        clr();
        for (int i = 0; i < 300; i++) xfer(0, 8'h61, 1'b0);
        send("", 0);
        wait_el(2);
        `CHK("first_chunk", pmp_pkg::BUF_BYTES, first_len)
        `CHK("el_count", 300, got.size())
        $display("test full buffer done");
        header_echo_control_in = 1'b0;
        xfer(1, 8'h31, 1'b0);
        xfer(1, 8'h32, 1'b1);
        rsp_valid_in = 1'b0;
        for (int w = 0; w < 5000 && pmp_ctrl_model_i.q.size() < 3; w++)
            step(1'b0);
        `CHK("tx_size", 3, pmp_ctrl_model_i.q.size())
        `CHK("tx_byte0", 9'h031, pmp_ctrl_model_i.q[0])
        `CHK("tx_byte1", 9'h032, pmp_ctrl_model_i.q[1])
        `CHK("tx_term", 9'h10a, pmp_ctrl_model_i.q[2])
        $display("test response done");
        finish_test();
    end
endmodule
`default_nettype wire
